// ---- verilog/svc_top.sv ----
// stereo volume serial control: link sampling, volume register, mute and calibration
//
// Contract
// - serial output not driven while chip select is high.
// - chip select falling starts a new 16-bit word.
// - chip select rising copies the shift register into the volume register while mute is high; a rise during mute is refused.
// - mute low forces both channel outputs to ground.
// - mute falling starts an offset calibration.
// - zero-cross enable high waits for crossing or timeout; low applies at once.
// - first eight bits set right level, next eight set left.
// - data sampled on rising serial clock, output changed on falling.
// - serial output repeats input delayed by sixteen bits for chaining.
// - all-zero level is software mute, maximum attenuation.
`timescale 1ns/1ps
module svc_top #(
    parameter int unsigned CAL_CYCLES = svc_pkg::CAL_CYCLES,
    parameter int unsigned ZC_CYCLES  = svc_pkg::ZC_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       chip_select_n,
    input  wire logic       serial_clock,
    input  wire logic       serial_in,
    input  wire logic       mute_n,
    input  wire logic       zero_cross_enable,
    input  wire logic       zero_cross_detect,
    output logic            serial_out_chain_o,
    output logic            serial_out_chain_oe,
    output logic [7:0]      right_output,
    output logic [7:0]      left_output,
    output logic            right_output_grounded,
    output logic            left_output_grounded,
    output logic            right_soft_muted,
    output logic            left_soft_muted,
    output logic            calibrating,
    output logic [15:0]     volume_word
);
    // --------------------------------------------------------------
    // pin synchronisers and edge detection
    // --------------------------------------------------------------
    logic [4:0] s1_q, s2_q, s3_q;
    logic [4:0] pins;

    if (CAL_CYCLES < 1 || ZC_CYCLES < 1) begin : g_bad_counts
        $error("svc_top: counts must be positive");
    end

    assign pins = {chip_select_n, serial_clock, serial_in, mute_n, zero_cross_detect};

    // reset to the idle pin levels so no false edge follows reset
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= 5'h12;
            s2_q <= 5'h12;
            s3_q <= 5'h12;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    logic cs_n_s, sclk_s, din_s, mute_n_s, zcd_s;
    logic cs_n_p, sclk_p, mute_n_p, zcd_p;
    assign {cs_n_s, sclk_s, din_s, mute_n_s, zcd_s} = s2_q;
    assign cs_n_p   = s3_q[4];
    assign sclk_p   = s3_q[3];
    assign mute_n_p = s3_q[1];
    assign zcd_p    = s3_q[0];

    logic zce_s1_q, zce_s2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            zce_s1_q <= 1'b0;
            zce_s2_q <= 1'b0;
        end else begin
            zce_s1_q <= zero_cross_enable;
            zce_s2_q <= zce_s1_q;
        end
    end

    svc_link_if lnk ();

    assign lnk.cs_high   = cs_n_s;
    assign lnk.cs_fall   = cs_n_p && !cs_n_s;
    assign lnk.cs_rise   = !cs_n_p && cs_n_s;
    assign lnk.sclk_rise = !sclk_p && sclk_s;
    assign lnk.sclk_fall = sclk_p && !sclk_s;
    assign lnk.din       = din_s;

    svc_shift #(
        .WIDTH (svc_pkg::WORD_BITS)
    ) u_shift (
        .clk (clk),
        .rst (rst),
        .lnk (lnk)
    );

    // --------------------------------------------------------------
    // daisy-chain output pin
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            serial_out_chain_o  <= 1'b0;
            serial_out_chain_oe <= 1'b0;
        end else begin
            serial_out_chain_o  <= lnk.dout;
            serial_out_chain_oe <= lnk.dout_en && !cs_n_s;
        end
    end

    // --------------------------------------------------------------
    // mute and offset calibration
    // --------------------------------------------------------------
    logic        mute_fall;
    logic        hw_mute;
    logic [31:0] cal_cnt_q;
    // a new mute restarts calibration and clears the volume register
    assign mute_fall = mute_n_p && !mute_n_s;
    assign hw_mute   = !mute_n_s;

    always_ff @(posedge clk) begin
        if (rst) begin
            cal_cnt_q   <= '0;
            calibrating <= 1'b0;
        end else if (mute_fall) begin
            cal_cnt_q   <= 32'(CAL_CYCLES);
            calibrating <= 1'b1;
        end else if (cal_cnt_q != '0) begin
            cal_cnt_q   <= cal_cnt_q - 32'h1;
            calibrating <= (cal_cnt_q != 32'h1);
        end else begin
            calibrating <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // volume control register
    // --------------------------------------------------------------
    logic word_commit;
    // a rise while muted is refused; the word stays in the shift register
    assign word_commit = lnk.cs_rise && !hw_mute;

    always_ff @(posedge clk) begin
        if (rst || mute_fall) begin
            volume_word <= svc_pkg::VOLUME_RESET;
        end else if (word_commit) begin
            volume_word <= lnk.word;
        end
    end

    // --------------------------------------------------------------
    // level transitions with zero-crossing or timeout
    // --------------------------------------------------------------
    svc_pkg::svc_lvl_state_t state_q;
    logic [31:0] zc_cnt_q;
    logic        zc_seen;
    logic [7:0]  right_target, left_target;
    // any toggle of the comparator counts as a crossing
    assign zc_seen      = zcd_s != zcd_p;
    assign right_target = volume_word[svc_pkg::RIGHT_LSB +: svc_pkg::LEVEL_BITS];
    assign left_target  = volume_word[svc_pkg::LEFT_LSB +: svc_pkg::LEVEL_BITS];

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= svc_pkg::SVC_LVL_IDLE;
            zc_cnt_q <= '0;
        end else begin
            case (state_q)
                svc_pkg::SVC_LVL_IDLE: begin
                    if ({right_target, left_target} != {right_output, left_output}) begin
                        if (zce_s2_q) begin
                            state_q  <= svc_pkg::SVC_LVL_WAIT;
                            zc_cnt_q <= 32'(ZC_CYCLES);
                        end else begin
                            state_q <= svc_pkg::SVC_LVL_APPLY;
                        end
                    end
                end
                svc_pkg::SVC_LVL_WAIT: begin
                    if (zc_seen || zc_cnt_q <= 32'h1 || !zce_s2_q) begin
                        state_q <= svc_pkg::SVC_LVL_APPLY;
                    end else begin
                        zc_cnt_q <= zc_cnt_q - 32'h1;
                    end
                end
                svc_pkg::SVC_LVL_APPLY: begin
                    state_q <= svc_pkg::SVC_LVL_IDLE;
                end
                default: begin
                    state_q <= svc_pkg::SVC_LVL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            right_output <= svc_pkg::LEVEL_MUTE;
            left_output  <= svc_pkg::LEVEL_MUTE;
        end else if (state_q == svc_pkg::SVC_LVL_APPLY) begin
            right_output <= right_target;
            left_output  <= left_target;
        end
    end

    // --------------------------------------------------------------
    // channel ground and soft-mute flags
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            right_output_grounded <= 1'b1;
            left_output_grounded  <= 1'b1;
            right_soft_muted      <= 1'b1;
            left_soft_muted       <= 1'b1;
        end else begin
            right_output_grounded <= hw_mute;
            left_output_grounded  <= hw_mute;
            right_soft_muted      <= (right_output == svc_pkg::LEVEL_MUTE);
            left_soft_muted       <= (left_output == svc_pkg::LEVEL_MUTE);
        end
    end
endmodule

// ---- verilog/svc_pkg.sv ----
// constants shared by the stereo volume serial control block
package svc_pkg;
    localparam int unsigned WORD_BITS      = 16;
    localparam int unsigned LEVEL_BITS     = 8;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned CAL_TIME_US    = 2000;
    localparam int unsigned CAL_CYCLES     = (CAL_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int unsigned ZC_TIMEOUT_US  = 18000;
    localparam int unsigned ZC_CYCLES      = (ZC_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam logic [15:0] VOLUME_RESET   = 16'h0000;
    localparam logic [7:0]  LEVEL_MUTE     = 8'h00;
    localparam int unsigned RIGHT_LSB      = 8;
    localparam int unsigned LEFT_LSB       = 0;
    typedef enum logic [1:0] {
        SVC_LVL_IDLE,
        SVC_LVL_WAIT,
        SVC_LVL_APPLY
    } svc_lvl_state_t;
endpackage

// ---- verilog/svc_link_if.sv ----
// serial link signals passed between the top and the shift engine
`timescale 1ns/1ps
interface svc_link_if;
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        cs_rise;
    logic        cs_high;
    logic        din;
    logic        dout;
    logic        dout_en;
    logic [15:0] word;
    modport top (output sclk_rise, sclk_fall, cs_fall, cs_rise, cs_high, din,
                 input dout, dout_en, word);
    modport eng (input sclk_rise, sclk_fall, cs_fall, cs_rise, cs_high, din,
                 output dout, dout_en, word);
endinterface

// ---- verilog/svc_shift.sv ----
// serial shift register and daisy-chain output
`timescale 1ns/1ps
module svc_shift #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic  clk,
    input  wire logic  rst,
    svc_link_if.eng    lnk
);
    logic [WIDTH-1:0] shift_q;
    logic             dout_q;
    logic             dout_en_q;

    if (WIDTH != svc_pkg::WORD_BITS) begin : g_bad_width
        $error("svc_shift: WIDTH must equal the link word width");
    end

    // bits enter at the low end on rising serial clock
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
        end else if (!lnk.cs_high && lnk.sclk_rise) begin
            shift_q <= {shift_q[WIDTH-2:0], lnk.din};
        end
    end

    // oldest bit leaves on falling serial clock, giving a sixteen-bit delay
    always_ff @(posedge clk) begin
        if (rst) begin
            dout_q <= 1'b0;
        end else if (lnk.cs_fall) begin
            dout_q <= shift_q[WIDTH-1];
        end else if (!lnk.cs_high && lnk.sclk_fall) begin
            dout_q <= shift_q[WIDTH-1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            dout_en_q <= 1'b0;
        end else begin
            dout_en_q <= !lnk.cs_high;
        end
    end

    assign lnk.dout    = dout_q;
    assign lnk.dout_en = dout_en_q;
    assign lnk.word    = shift_q;
endmodule

// ---- verification/svc_host_model.sv ----
// host side of the serial link: frames, link clock and chain capture
`timescale 1ns/1ps
module svc_host_model (
    output logic        cs_n,
    output logic        sclk,
    output logic        sdi,
    input  wire logic   sdo,
    output logic [15:0] chain_q
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        chain_q = 16'h0000;
    end
    // link clock runs only inside a frame; released data goes to its inverse
    task automatic send(input logic [31:0] w);
        cs_n <= 1'b0;
        #125;
        for (int i = 31; i >= 0; i--) begin
            sdi <= w[i];
            #62.5 sclk <= 1'b1;
            chain_q <= {chain_q[14:0], sdo};
            #62.5 sclk <= 1'b0;
        end
        #125 cs_n <= 1'b1;
        sdi <= ~sdi;
    endtask
endmodule

// ---- verification/svc_top_properties.sv ----
// concurrent checks on the volume control top ports
`timescale 1ns/1ps
module svc_top_properties #(
    parameter int unsigned CAL_CYCLES = 20,
    parameter int unsigned ZC_CYCLES  = 50
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        chip_select_n,
    input wire logic        serial_clock,
    input wire logic        serial_in,
    input wire logic        mute_n,
    input wire logic        zero_cross_enable,
    input wire logic        serial_out_chain_oe,
    input wire logic [7:0]  right_output,
    input wire logic [7:0]  left_output,
    input wire logic        right_output_grounded,
    input wire logic        left_output_grounded,
    input wire logic        calibrating,
    input wire logic [15:0] volume_word
);
    localparam int ZC_MAX = ZC_CYCLES + 8;
    logic [3:0]  since_q;
    logic [15:0] shadow_q;
    logic [31:0] cal_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    always_ff @(posedge clk) begin
        if (rst || $rose(chip_select_n) || $fell(mute_n)) since_q <= 4'h0;
        else if (since_q != 4'hf) since_q <= since_q + 4'h1;
    end
    // mirror of the bits shifted in at the pins
    always_ff @(posedge clk) begin
        if (rst) shadow_q <= 16'h0000;
        else if ($rose(serial_clock) && !chip_select_n) shadow_q <= {shadow_q[14:0], serial_in};
    end
    always_ff @(posedge clk) begin
        cal_q <= calibrating ? cal_q + 32'h1 : 32'h0;
    end
    property p_oe_idle; chip_select_n [*5] |-> !serial_out_chain_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("chain output driven while deselected");
    property p_oe_drive; !chip_select_n [*5] |-> serial_out_chain_oe; endproperty
    a_oe_drive: assert property (p_oe_drive) else $error("chain output idle in frame");
    property p_load; $rose(chip_select_n) && mute_n |-> ##5 volume_word == shadow_q; endproperty
    a_load: assert property (p_load) else $error("volume word not loaded");
    property p_hold; $changed(volume_word) |-> since_q < 4'h7; endproperty
    a_hold: assert property (p_hold) else $error("volume word changed between loads");
    property p_ground;
        !mute_n [*4] |-> right_output_grounded && left_output_grounded;
    endproperty
    a_ground: assert property (p_ground) else $error("outputs not grounded in mute");
    property p_cal; $fell(mute_n) |-> ##[1:5] calibrating; endproperty
    a_cal: assert property (p_cal) else $error("calibration not started");
    property p_cal_len;
        $fell(calibrating) |-> cal_q >= CAL_CYCLES && cal_q <= CAL_CYCLES + 1;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("calibration length wrong");
    property p_zc_off; $changed(volume_word) && !zero_cross_enable && mute_n
        |-> ##[1:4] {right_output, left_output} == volume_word; endproperty
    a_zc_off: assert property (p_zc_off) else $error("level not applied at once");
    property p_zc_to; $changed(volume_word) && zero_cross_enable && mute_n
        |-> ##[1:ZC_MAX] {right_output, left_output} == volume_word; endproperty
    a_zc_to: assert property (p_zc_to) else $error("level not applied by timeout");
    c_frame: cover property ($rose(chip_select_n) && mute_n);
    c_zc: cover property ($changed(volume_word) && zero_cross_enable);
    c_cal: cover property ($fell(calibrating));
endmodule
bind svc_top svc_top_properties #(.CAL_CYCLES(CAL_CYCLES), .ZC_CYCLES(ZC_CYCLES))
    i_svc_top_properties (.*);

// ---- verification/tb_top.sv ----
// self-checking bench for the volume control top
`timescale 1ns/1ps
module tb_top;
    logic        clk, rst, mute_n, zce, zcd, so, soe, cal, rg, lg, rs, ls, so_last;
    logic        cs_n, sclk, sdi;
    logic [7:0]  ro, lo;
    logic [15:0] vw, chain;
    logic [31:0] lfsr, w;
    int          num_errors, check_count, cyc;
    wire         sdo = soe ? so : ~so_last;
    svc_top #(.CAL_CYCLES(20), .ZC_CYCLES(50)) i_svc_top (
        .clk(clk), .rst(rst), .chip_select_n(cs_n), .serial_clock(sclk), .serial_in(sdi),
        .mute_n(mute_n), .zero_cross_enable(zce), .zero_cross_detect(zcd),
        .serial_out_chain_o(so), .serial_out_chain_oe(soe), .right_output(ro),
        .left_output(lo), .right_output_grounded(rg), .left_output_grounded(lg),
        .right_soft_muted(rs), .left_soft_muted(ls), .calibrating(cal), .volume_word(vw));
    svc_host_model i_svc_host_model (
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .chain_q(chain));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] lvl(input logic [15:0] v, input logic r);
        return r ? {8'h00, v[15:8]} : {8'h00, v[7:0]};
    endfunction
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        zcd <= cyc[5];
        if (soe) so_last <= so;
        if (cyc == 40000) begin
            num_errors++;
            report_and_stop();
        end
    end
    initial begin
        {rst, mute_n, zce, zcd, so_last, num_errors, check_count, cyc} = {3'b110, 2'b00, 96'h0};
        lfsr = 32'hc73e;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        // zero word and full word first, then random frames
        for (int k = 0; k < 14; k++) begin
            lfsr = nxt(nxt(lfsr));
            w = (k == 0) ? {lfsr[31:16], 16'h0000} : (k == 1) ? {lfsr[15:0], 16'hffff} : lfsr;
            zce <= lfsr[4];
            i_svc_host_model.send(w);
            repeat (6) @(posedge clk);
            for (int t = 0; t < 100 && {ro, lo} !== w[15:0]; t++) @(posedge clk);
            repeat (2) @(posedge clk);
            chk("volume_word", w[15:0], vw);
            chk("right_output", lvl(w[15:0], 1'b1), {8'h00, ro});
            chk("left_output", lvl(w[15:0], 1'b0), {8'h00, lo});
            chk("right_soft", {15'h0, lvl(w[15:0], 1'b1) == 16'h0}, {15'h0, rs});
            chk("left_soft", {15'h0, lvl(w[15:0], 1'b0) == 16'h0}, {15'h0, ls});
            chk("chain", w[31:16], chain);
            chk("oe", 16'h0, {15'h0, soe});
        end
        @(posedge clk) mute_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("calibrating", 16'h1, {15'h0, cal});
        chk("grounded", 16'h3, {14'h0, rg, lg});
        chk("volume_word", 16'h0, vw);
        i_svc_host_model.send(32'h1234_5678);
        repeat (8) @(posedge clk);
        chk("volume_word", 16'h0, vw);
        chk("calibrating", 16'h0, {15'h0, cal});
        mute_n <= 1'b1;
        repeat (8) @(posedge clk);
        chk("grounded", 16'h0, {14'h0, rg, lg});
        report_and_stop();
    end
endmodule
